// ===== sdtc_dev_model.sv
// Behavioural model of the SCSI chip's DMA handshake side.
`timescale 1ns/10ps
`default_nettype none
module sdtc_dev_model
(
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic dma_en, // Device DMA enable, set by software.
  input wire logic slow, // Throttles block-mode strobes.
  input wire logic dma_grant_in_n, // Grant.
  input wire logic read_strobe_n, // Read strobe.
  input wire logic write_strobe_n, // Write strobe.
  input wire logic end_of_process_in_n, // End-of-process.
  input wire logic [7:0] data_out, // Data from the controller.
  input wire logic data_oe, // Controller drives the data bus.
  output logic dma_request_out, // Request.
  output logic dev_ready, // Ready.
  output logic [7:0] data_in, // Data to the controller.
  output logic [15:0] n_bytes, // Bytes moved so far.
  output logic [7:0] last_wr, // Last byte written.
  output logic transfer_done_flag // End-of-process recognised.
);
  import sdtc_pkg::*;
  logic [2:0] pace_reg;
  logic [2:0] eop_cnt_reg;
  logic rd_d_reg;
  logic wr_d_reg;
  logic [7:0] last_rd_reg;
  // An idle data bus shows the inverse of the last byte so stale data never matches.
  assign data_in = read_strobe_n ? ~last_rd_reg : 8'h50 + n_bytes[7:0];
  assign dev_ready = !slow || pace_reg[2];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dma_request_out <= 1'b0;
      pace_reg <= 3'h0;
    end
    else
    begin
      dma_request_out <= dma_en && dma_grant_in_n;
      pace_reg <= pace_reg + 3'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_d_reg <= 1'b1;
      wr_d_reg <= 1'b1;
      n_bytes <= 16'h0;
      last_wr <= 8'h00;
      last_rd_reg <= 8'h00;
    end
    else
    begin
      rd_d_reg <= read_strobe_n;
      wr_d_reg <= write_strobe_n;
      // Data is taken only while the controller really drives the bus.
      if (!dma_grant_in_n && !write_strobe_n && data_oe)
        last_wr <= data_out;
      if (!dma_grant_in_n && write_strobe_n && !wr_d_reg)
        n_bytes <= n_bytes + 16'h1;
      if (!dma_grant_in_n && read_strobe_n && !rd_d_reg)
      begin
        last_rd_reg <= 8'h50 + n_bytes[7:0];
        n_bytes <= n_bytes + 16'h1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      eop_cnt_reg <= 3'h0;
      transfer_done_flag <= 1'b0;
    end
    else if (!dma_en)
    begin
      eop_cnt_reg <= 3'h0;
      transfer_done_flag <= 1'b0;
    end
    else if (!end_of_process_in_n && !dma_grant_in_n && !(read_strobe_n && write_strobe_n))
    begin
      eop_cnt_reg <= eop_cnt_reg + 3'h1;
      if (eop_cnt_reg >= SDTC_EOP_CYC - 1)
        transfer_done_flag <= 1'b1;
    end
    else
      eop_cnt_reg <= 3'h0;
  end
endmodule
`default_nettype wire

// ===== sdtc_host.sv
// DMA-side host controller driving the SCSI chip's byte handshake pins.
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module sdtc_host
(
  input wire logic pclk, // Clock, 40 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error.
  input wire logic dma_request_out, // Request from the device.
  input wire logic dev_ready, // Ready output of the device.
  output logic dma_grant_in_n, // Grant to the device.
  output logic read_strobe_n, // Read strobe.
  output logic write_strobe_n, // Write strobe.
  output logic end_of_process_in_n, // End-of-process to the device.
  output logic chip_select_n, // Chip select, held inactive by this controller.
  input wire logic [7:0] data_in, // Data bus from the device.
  output logic [7:0] data_out, // Data bus to the device.
  output logic data_oe // Data bus output enable.
);
  import sdtc_pkg::*;
  sdtc_state_e state_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] wdata_reg;
  logic wfull_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic done_reg;
  logic [15:0] count_reg;
  logic wr_acc;
  logic rd_dir;
  logic last_byte;
  sdtc_timer_if tif();

  sdtc_timer u_timer
  (
    .pclk(pclk),
    .presetn(presetn),
    .tif(tif)
  );

  assign wr_acc = psel && penable && pwrite;
  assign pready = 1'b1;
  assign rd_dir = ctrl_reg[SDTC_CTRL_DIR_RD];
  assign last_byte = (count_reg == 16'h0001);
  // Grant access never uses chip select.
  assign chip_select_n = 1'b1;

  always_comb
  begin
    pslverr = 1'b0;
    prdata = 32'h0000_0000;
    if (psel && penable)
    begin
      case (paddr)
        SDTC_CTRL_OFS: prdata = {24'h00_0000, ctrl_reg};
        SDTC_STAT_OFS: prdata = {27'h000_0000, rvalid_reg, wfull_reg, dma_request_out, done_reg,
          state_reg != SDTC_IDLE};
        SDTC_WDATA_OFS: prdata = {24'h00_0000, wdata_reg};
        SDTC_RDATA_OFS: prdata = {24'h00_0000, rdata_reg};
        SDTC_COUNT_OFS: prdata = {16'h0000, count_reg};
        default: pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= SDTC_CTRL_RST;
    else if (wr_acc && paddr == SDTC_CTRL_OFS)
      ctrl_reg <= pwdata[7:0];
    else if (state_reg == SDTC_GAP && count_reg == 16'h0000)
      ctrl_reg[SDTC_CTRL_GO] <= 1'b0;
    else if (ctrl_reg[SDTC_CTRL_ABORT] && state_reg == SDTC_IDLE)
      ctrl_reg[SDTC_CTRL_ABORT] <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_reg <= 16'h0000;
    else if (wr_acc && paddr == SDTC_COUNT_OFS)
      count_reg <= pwdata[15:0];
    else if (state_reg == SDTC_STROBE && tif.expired && count_reg != 16'h0000)
      count_reg <= count_reg - 16'h0001;
  end

  // Write buffer: set by software, emptied by a write strobe; the set wins.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdata_reg <= 8'h00;
      wfull_reg <= 1'b0;
    end
    else if (wr_acc && paddr == SDTC_WDATA_OFS)
    begin
      wdata_reg <= pwdata[7:0];
      wfull_reg <= 1'b1;
    end
    else if (state_reg == SDTC_STROBE && tif.expired && !rd_dir)
      wfull_reg <= 1'b0;
  end

  // Read byte kept until software reads it; a new byte wins over the read.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end
    else if (state_reg == SDTC_STROBE && tif.expired && rd_dir)
    begin
      rdata_reg <= data_in;
      rvalid_reg <= 1'b1;
    end
    else if (psel && penable && !pwrite && paddr == SDTC_RDATA_OFS)
      rvalid_reg <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_reg <= 1'b0;
    else if (state_reg == SDTC_GAP && count_reg == 16'h0000)
      done_reg <= 1'b1;
    else if (wr_acc && paddr == SDTC_STAT_OFS && pwdata[SDTC_STAT_DONE])
      done_reg <= 1'b0;
  end

  always_comb
  begin
    tif.load = 1'b0;
    tif.count = 8'h00;
    if (state_reg == SDTC_GRANT && (!ctrl_reg[SDTC_CTRL_BLOCK] || dev_ready)
      && (rd_dir ? !rvalid_reg : wfull_reg))
    begin
      tif.load = 1'b1;
      // The strobe flop lags the timer by one cycle, so the full count is loaded.
      tif.count = 8'(SDTC_STROBE_CYC);
    end
    else if (state_reg == SDTC_RELEASE)
    begin
      tif.load = 1'b1;
      tif.count = 8'(SDTC_GAP_CYC - 1);
    end
  end

  // Sequencer: normal mode waits for a request per byte; block mode holds grant.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= SDTC_IDLE;
    else
    begin
      case (state_reg)
        SDTC_IDLE:
          if (ctrl_reg[SDTC_CTRL_GO] && !ctrl_reg[SDTC_CTRL_ABORT] && count_reg != 16'h0000)
            state_reg <= SDTC_WAIT_REQ;
        SDTC_WAIT_REQ:
          if (ctrl_reg[SDTC_CTRL_ABORT])
            state_reg <= SDTC_IDLE;
          else if (dma_request_out && (rd_dir ? !rvalid_reg : wfull_reg))
            state_reg <= SDTC_GRANT;
        SDTC_GRANT:
          if (tif.load)
            state_reg <= SDTC_STROBE;
        SDTC_STROBE:
          if (tif.expired)
            state_reg <= SDTC_RELEASE;
        SDTC_RELEASE:
          state_reg <= SDTC_GAP;
        SDTC_GAP:
          if (count_reg == 16'h0000)
            state_reg <= SDTC_IDLE;
          else if (tif.expired)
            state_reg <= ctrl_reg[SDTC_CTRL_BLOCK] ? SDTC_GRANT : SDTC_WAIT_REQ;
        default:
          state_reg <= SDTC_IDLE;
      endcase
    end
  end

  // Grant: held through a block, dropped after each byte otherwise, which cycles it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dma_grant_in_n <= 1'b1;
    else if (state_reg == SDTC_GRANT || state_reg == SDTC_STROBE)
      dma_grant_in_n <= 1'b0;
    else if ((state_reg == SDTC_RELEASE || state_reg == SDTC_GAP) && ctrl_reg[SDTC_CTRL_BLOCK]
      && count_reg != 16'h0000)
      dma_grant_in_n <= 1'b0;
    else
      dma_grant_in_n <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end
    else
    begin
      read_strobe_n <= !(state_reg == SDTC_STROBE && rd_dir && !tif.expired);
      write_strobe_n <= !(state_reg == SDTC_STROBE && !rd_dir && !tif.expired);
    end
  end

  // End-of-process spans the whole strobe of the last byte, at least 100 ns.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      end_of_process_in_n <= 1'b1;
    else
      end_of_process_in_n <= !(state_reg == SDTC_STROBE && !tif.expired && last_byte
        && ctrl_reg[SDTC_CTRL_EOP_LAST]);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end
    else
    begin
      data_out <= wdata_reg;
      data_oe <= (state_reg == SDTC_STROBE) && !rd_dir && !tif.expired;
    end
  end

  AST_NO_CS_WITH_GRANT: assert property (@(posedge pclk) disable iff (!presetn)
    !(!dma_grant_in_n && !chip_select_n)) else $error("Grant and chip select both active.");
  AST_STROBE_UNDER_GRANT: assert property (@(posedge pclk) disable iff (!presetn)
    (!read_strobe_n || !write_strobe_n) |-> !dma_grant_in_n) else $error("Strobe without grant.");
  AST_STROBE_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(write_strobe_n) |-> !write_strobe_n [*4]) else $error("Write strobe too short.");
  AST_RD_STROBE_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(read_strobe_n) |-> !read_strobe_n [*4]) else $error("Read strobe too short.");
  AST_EOP_WITH_STROBE: assert property (@(posedge pclk) disable iff (!presetn)
    !end_of_process_in_n |-> (!dma_grant_in_n && (!read_strobe_n || !write_strobe_n)))
    else $error("End-of-process outside a strobe.");
  AST_EOP_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(end_of_process_in_n) |-> !end_of_process_in_n [*4]) else $error("End-of-process too short.");
  AST_NORMAL_GRANT_CYCLES: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(write_strobe_n) && !ctrl_reg[SDTC_CTRL_BLOCK]) |-> ##[1:3] dma_grant_in_n)
    else $error("Grant not released after byte.");
  AST_ONE_BYTE_PER_STROBE: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == SDTC_STROBE && tif.expired && count_reg != 16'h0000 && !(wr_acc && paddr == SDTC_COUNT_OFS))
    |=> count_reg == $past(count_reg) - 16'h0001) else $error("Byte count slip.");
  AST_BLOCK_HOLDS_GRANT: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_reg[SDTC_CTRL_BLOCK] && (state_reg == SDTC_RELEASE || state_reg == SDTC_GAP)
    && count_reg != 16'h0000 && !dma_grant_in_n) |=> !dma_grant_in_n) else $error("Block grant dropped.");
endmodule
`default_nettype wire

// ===== sdtc_host_tb_top.sv
// Self-checking testbench of the SCSI DMA host controller.
`timescale 1ns/10ps
`default_nettype none
module sdtc_host_tb_top;
  import sdtc_pkg::*;
  typedef struct {logic rd; logic blk; logic eop; logic slow; logic [7:0] n;} sdtc_row_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic dma_en = 1'b0;
  logic slow = 1'b0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, dma_request_out, dev_ready, dma_grant_in_n, read_strobe_n, write_strobe_n;
  wire logic end_of_process_in_n, chip_select_n, data_oe, transfer_done_flag;
  wire logic [7:0] data_in, data_out, last_wr;
  wire logic [15:0] n_bytes;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  logic [31:0] q;
  logic e;
  logic [15:0] base;
  sdtc_row_s rows [6] = '{'{0,0,0,0,8'h02}, '{0,0,1,0,8'h01}, '{0,1,1,1,8'h03},
                         '{1,0,0,0,8'h02}, '{1,1,1,1,8'h03}, '{1,1,0,0,8'h01}};
  sdtc_host dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_request_out(dma_request_out), .dev_ready(dev_ready), .dma_grant_in_n(dma_grant_in_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .end_of_process_in_n(end_of_process_in_n),
    .chip_select_n(chip_select_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  sdtc_dev_model dev_u (.pclk(pclk), .presetn(presetn), .dma_en(dma_en), .slow(slow),
    .dma_grant_in_n(dma_grant_in_n), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .end_of_process_in_n(end_of_process_in_n), .data_out(data_out), .dma_request_out(dma_request_out),
    .dev_ready(dev_ready), .data_in(data_in), .n_bytes(n_bytes), .last_wr(last_wr), .data_oe(data_oe),
    .transfer_done_flag(transfer_done_flag));
  always #12.5 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic poll(input int b, input logic v);
    int k;
    k = 0;
    apb(1'b0, SDTC_STAT_OFS, 32'h0);
    while (q[b] !== v && k < 300)
    begin
      apb(1'b0, SDTC_STAT_OFS, 32'h0);
      k++;
    end
    chk(q[b], v);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      print_verdict();
    end
    if (presetn && !dma_grant_in_n)
      chk(chip_select_n, 1'b1);
  end
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, SDTC_CTRL_OFS, 32'h0);
    chk(q, {24'h0, SDTC_CTRL_RST});
    apb(1'b0, SDTC_STAT_OFS, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    chk(32'(e), 32'h1);
    $display("reset and map test done");
    foreach (rows[t])
    begin
      base = n_bytes;
      slow <= rows[t].slow;
      dma_en <= 1'b0;
      apb(1'b1, SDTC_COUNT_OFS, {24'h0, rows[t].n});
      dma_en <= 1'b1;
      apb(1'b1, SDTC_STAT_OFS, 32'h2);
      if (!rows[t].rd)
        apb(1'b1, SDTC_WDATA_OFS, 32'hA0);
      apb(1'b1, SDTC_CTRL_OFS, {28'h0, rows[t].eop, rows[t].blk, rows[t].rd, 1'b1});
      for (int i = 0; i < rows[t].n; i++)
      begin
        if (rows[t].rd)
        begin
          poll(SDTC_STAT_RVALID, 1'b1);
          apb(1'b0, SDTC_RDATA_OFS, 32'h0);
          chk(q, {24'h0, 8'h50 + base[7:0] + 8'(i)});
        end
        else if (i > 0)
        begin
          poll(SDTC_STAT_WFULL, 1'b0);
          apb(1'b1, SDTC_WDATA_OFS, {24'h0, 8'hA0 + 8'(i)});
        end
      end
      poll(SDTC_STAT_BUSY, 1'b0);
      chk(q[SDTC_STAT_DONE], 1'b1);
      chk(n_bytes, base + 16'(rows[t].n));
      if (!rows[t].rd)
        chk(last_wr, 8'hA0 + rows[t].n - 8'h1);
      chk(transfer_done_flag, rows[t].eop);
      $display("row test %0d done", t);
    end
    poll(SDTC_STAT_DREQ, 1'b1);
    dma_en <= 1'b0;
    poll(SDTC_STAT_DREQ, 1'b0);
    dma_en <= 1'b1;
    base = n_bytes;
    apb(1'b1, SDTC_COUNT_OFS, 32'h3);
    apb(1'b1, SDTC_WDATA_OFS, 32'h5A);
    apb(1'b1, SDTC_CTRL_OFS, 32'h1);
    poll(SDTC_STAT_WFULL, 1'b0);
    apb(1'b1, SDTC_CTRL_OFS, 32'h10);
    poll(SDTC_STAT_BUSY, 1'b0);
    apb(1'b0, SDTC_COUNT_OFS, 32'h0);
    chk(q, 32'h2);
    chk(n_bytes, base + 16'h1);
    chk(last_wr, 8'h5A);
    $display("abort test done");
    print_verdict();
  end
endmodule
`default_nettype wire

// ===== sdtc_pkg.sv
// Package with constants for the SCSI data-transfer host controller.
package sdtc_pkg;
  // Own APB register map.
  localparam logic [7:0] SDTC_CTRL_OFS = 8'h00;
  localparam logic [7:0] SDTC_STAT_OFS = 8'h04;
  localparam logic [7:0] SDTC_WDATA_OFS = 8'h08;
  localparam logic [7:0] SDTC_RDATA_OFS = 8'h0C;
  localparam logic [7:0] SDTC_COUNT_OFS = 8'h10;
  // Control fields.
  localparam int SDTC_CTRL_GO = 0;
  localparam int SDTC_CTRL_DIR_RD = 1;
  localparam int SDTC_CTRL_BLOCK = 2;
  localparam int SDTC_CTRL_EOP_LAST = 3;
  localparam int SDTC_CTRL_ABORT = 4;
  // Status fields.
  localparam int SDTC_STAT_BUSY = 0;
  localparam int SDTC_STAT_DONE = 1;
  localparam int SDTC_STAT_DREQ = 2;
  localparam int SDTC_STAT_WFULL = 3;
  localparam int SDTC_STAT_RVALID = 4;
  // Timing at 40 MHz.
  localparam int SDTC_CLK_MHZ = 40;
  localparam int SDTC_STROBE_NS = 100;
  localparam int SDTC_EOP_NS = 100;
  localparam int SDTC_STROBE_CYC = (SDTC_STROBE_NS * SDTC_CLK_MHZ + 999) / 1000;
  localparam int SDTC_EOP_CYC = (SDTC_EOP_NS * SDTC_CLK_MHZ + 999) / 1000;
  localparam int SDTC_GAP_CYC = 2;
  localparam logic [7:0] SDTC_CTRL_RST = 8'h00;
  typedef enum logic [2:0]
  {
    SDTC_IDLE = 3'b000,
    SDTC_WAIT_REQ = 3'b001,
    SDTC_GRANT = 3'b010,
    SDTC_STROBE = 3'b011,
    SDTC_RELEASE = 3'b100,
    SDTC_GAP = 3'b101
  } sdtc_state_e;
endpackage

// ===== sdtc_timer.sv
// Down-counting cycle timer that paces strobe and gap widths.
`timescale 1ns/10ps
`default_nettype none
module sdtc_timer
(
  input wire logic pclk, // Clock.
  input wire logic presetn, // Asynchronous reset, active low.
  sdtc_timer_if.timer tif // Load and expiry.
);
  logic [7:0] left_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      left_reg <= 8'h00;
    else if (tif.load)
      left_reg <= tif.count;
    else if (left_reg != 8'h00)
      left_reg <= left_reg - 8'h01;
  end
  assign tif.expired = (left_reg == 8'h00) && !tif.load;
endmodule
`default_nettype wire

// ===== sdtc_timer_if.sv
// Interface between the transfer sequencer and its cycle timer.
`timescale 1ns/10ps
`default_nettype none
interface sdtc_timer_if;
  logic load;
  logic [7:0] count;
  logic expired;
  modport master (output load, output count, input expired);
  modport timer (input load, input count, output expired);
endinterface
`default_nettype wire
